// File: src/media_alu_map.vh
// opcode encodings, lane geometry and saturation limits for the packed media alu
// included by every design file of the block
`ifndef MEDIA_ALU_MAP_VH
`define MEDIA_ALU_MAP_VH

`define OPC_W            5
`define OP_ABS32         5'h00
`define OP_ADD32_S       5'h01
`define OP_ADD32_U       5'h02
`define OP_MUL32_S       5'h03
`define OP_SUB32_S       5'h04
`define OP_DUAL_ASR      5'h05
`define OP_DUAL_ICLIP    5'h06
`define OP_DUAL_UCLIP    5'h07
`define OP_DUAL_SUB      5'h08
`define OP_HALF_LO_PACK  5'h09
`define OP_HALF_HI_PACK  5'h0a
`define OP_TWIN_LO_MERGE 5'h0b
`define OP_QUAD_MAX      5'h0c
`define OP_QUAD_MIN      5'h0d
`define OP_QUAD_MULHI    5'h0e
`define OP_QUAD_ADDUI    5'h0f
`define OP_HALF_DOT      5'h10
`define OP_BYTE_DOT      5'h11
`define OP_BYTE_SAD      5'h12
`define OP_QUAD_AVG      5'h13
`define OP_DUAL_ADD      5'h14
`define OP_DUAL_ABS      5'h15

`define S32_MAX          32'h7fffffff
`define S32_MIN          32'h80000000
`define U32_MAX          32'hffffffff
`define S16_MAX          16'h7fff
`define S16_MIN          16'h8000
`define U8_MAX           8'hff
`define SHAMT_W          4
`define LANE_ROUND       9'h001

`endif

// File: src/half_lane_unit.v
// one signed 16-bit lane: shift, clips, saturating add/sub/abs
// combinational; the parent keeps lane operands apart, but both lanes take their shift amount from b[3:0]
`timescale 1ns/1ps
`include "media_alu_map.vh"

module half_lane_unit
(
  // operation
  input  wire [`OPC_W-1:0] opcode,
  input  wire [3:0]        shamt,
  // lane operands
  input  wire [15:0]       a,
  input  wire [15:0]       b,
  // lane result
  output reg  [15:0]       y
);

  wire signed [15:0] sa   = a;
  wire signed [15:0] sb   = b;
  wire signed [16:0] sum  = {sa[15], sa} + {sb[15], sb};
  wire signed [16:0] dif  = {sa[15], sa} - {sb[15], sb};
  wire signed [16:0] neg  = 17'h00000 - {sa[15], sa};
  wire signed [15:0] nb   = 16'h0000 - sb;

  function [15:0] sat16;
    input [16:0] v;
    begin
      if (v[16] != v[15])
        sat16 = v[16] ? `S16_MIN : `S16_MAX;
      else
        sat16 = v[15:0];
    end
  endfunction

  always @*
  begin
    case (opcode)
      `OP_DUAL_ASR:   y = sa >>> shamt;
      `OP_DUAL_ICLIP:
      begin
        // range is [-b, b]; a negative bound clips to it as given
        if (sa > sb)
          y = b;
        else if (sa < nb)
          y = nb;
        else
          y = a;
      end
      `OP_DUAL_UCLIP:
      begin
        if (sa[15])
          y = 16'h0000;
        else if (sa > sb)
          y = b;
        else
          y = a;
      end
      `OP_DUAL_ADD:   y = sat16(sum);
      `OP_DUAL_SUB:   y = sat16(dif);
      `OP_DUAL_ABS:   y = sa[15] ? sat16(neg) : a;
      default:        y = 16'h0000;
    endcase
  end

endmodule // half_lane_unit

// File: src/byte_lane_unit.v
// one unsigned/signed byte lane: max, min, average, mul-high, clipped add,
// plus the lane's signed product and absolute difference for the reductions
`timescale 1ns/1ps
`include "media_alu_map.vh"

module byte_lane_unit
(
  // operation
  input  wire [`OPC_W-1:0] opcode,
  // lane operands
  input  wire [7:0]        a,
  input  wire [7:0]        b,
  // lane results
  output reg  [7:0]        y,
  output wire [15:0]       sprod,
  output wire [7:0]        sabs
);

  wire [15:0]        uprod = a * b;
  wire [8:0]         avg   = {1'b0, a} + {1'b0, b} + `LANE_ROUND;
  wire signed [9:0]  usum  = $signed({2'b00, a}) + $signed({{2{b[7]}}, b});
  wire signed [8:0]  sdif  = $signed({a[7], a}) - $signed({b[7], b});
  // magnitude of a signed byte difference never exceeds 255
  wire [8:0]         sneg  = 9'h000 - sdif;

  assign sprod = $signed(a) * $signed(b);
  assign sabs  = sdif[8] ? sneg[7:0] : sdif[7:0];

  always @*
  begin
    case (opcode)
      `OP_QUAD_MAX:   y = (a > b) ? a : b;
      `OP_QUAD_MIN:   y = (a < b) ? a : b;
      `OP_QUAD_MULHI: y = uprod[15:8];
      `OP_QUAD_AVG:   y = avg[8:1];
      `OP_QUAD_ADDUI:
      begin
        if (usum[9])
          y = 8'h00;
        else if (usum[8])
          y = `U8_MAX;
        else
          y = usum[7:0];
      end
      default:        y = 8'h00;
    endcase
  end

endmodule // byte_lane_unit

// File: src/packed_simd_media_alu.v
// packed simd media alu: several issue slots of clipped 32-bit, dual-16
// and quad-8 operations, one register stage per slot
// assumes operands arrive from the register file with a valid each cycle
//
// Function
// - 32-bit absolute value, saturating the most negative input
// - signed 32-bit add clipped to signed range on overflow
// - unsigned 32-bit add clipped to all ones on overflow
// - signed 32-bit multiply clipped to signed 32-bit range
// - signed 32-bit subtract clipped to signed range on overflow
// - each halfword shifted right arithmetically on its own
// - each signed halfword clipped to signed range from second operand
// - each signed halfword clipped to zero..bound
// - halfword subtract, each lane clipped to signed 16-bit
// - pack low halfwords of both sources
// - pack high halfwords of both sources
// - merge low bytes of each halfword of both sources
// - bytewise unsigned maximum
// - bytewise unsigned minimum
// - bytewise unsigned multiply, keep product high byte
// - unsigned plus signed bytes, clipped to byte range
// - signed sum of signed lane products
// - unsigned sum of absolute signed byte differences
// - up to five operations issue per cycle
// - bytewise average rounds up: (a+b+1)>>1
// - clipped byte add gives 0 below zero, 255 above
`timescale 1ns/1ps
`include "media_alu_map.vh"

module packed_simd_media_alu
#(
  parameter SLOTS = 5
)
(
  // clock and reset
  input  wire                    clk,
  input  wire                    reset,
  // issue side, slot i in bits of width per slot
  input  wire [SLOTS-1:0]        issue_valid,
  input  wire [SLOTS*`OPC_W-1:0] issue_opcode,
  input  wire [SLOTS*32-1:0]     issue_src1,
  input  wire [SLOTS*32-1:0]     issue_src2,
  // writeback side
  output reg  [SLOTS-1:0]        result_valid_ff,
  output reg  [SLOTS*32-1:0]     result_data_ff
);

  // one word per slot, already zeroed for idle slots
  wire [SLOTS*32-1:0] nxt_result_data;

  genvar s;
  // every slot has its own full alu so a bundle never stalls
  generate
    for (s = 0; s < SLOTS; s = s + 1)
    begin : slot
      wire [`OPC_W-1:0] op = issue_opcode[s*`OPC_W +: `OPC_W];
      wire [31:0]       a  = issue_src1[s*32 +: 32];
      wire [31:0]       b  = issue_src2[s*32 +: 32];

      wire [15:0] h_y [0:1];
      wire [7:0]  q_y [0:3];
      wire [15:0] q_p [0:3];
      wire [7:0]  q_d [0:3];

      genvar l;
      for (l = 0; l < 2; l = l + 1)
      begin : half
        half_lane_unit u_half
        (
          .opcode (op),
          .shamt  (b[`SHAMT_W-1:0]),
          .a      (a[l*16 +: 16]),
          .b      (b[l*16 +: 16]),
          .y      (h_y[l])
        );
      end
      for (l = 0; l < 4; l = l + 1)
      begin : quad
        byte_lane_unit u_byte
        (
          .opcode (op),
          .a      (a[l*8 +: 8]),
          .b      (b[l*8 +: 8]),
          .y      (q_y[l]),
          .sprod  (q_p[l]),
          .sabs   (q_d[l])
        );
      end

      // 32-bit clipped arithmetic
      wire [32:0] uadd  = {1'b0, a} + {1'b0, b};
      wire [32:0] sadd  = {a[31], a} + {b[31], b};
      wire [32:0] ssub  = {a[31], a} - {b[31], b};
      wire [63:0] smul  = $signed(a) * $signed(b);
      wire [31:0] neg_a = 32'h00000000 - a;

      // halfword products summed in 32 bits; wraps only for two full-negative pairs
      wire [31:0] hp0 = $signed(a[15:0]) * $signed(b[15:0]);
      wire [31:0] hp1 = $signed(a[31:16]) * $signed(b[31:16]);
      wire [31:0] hdot = hp0 + hp1;

      wire [31:0] bdot = {{16{q_p[0][15]}}, q_p[0]} + {{16{q_p[1][15]}}, q_p[1]}
                       + {{16{q_p[2][15]}}, q_p[2]} + {{16{q_p[3][15]}}, q_p[3]};
      wire [9:0]  bsad = {2'b00, q_d[0]} + {2'b00, q_d[1]}
                       + {2'b00, q_d[2]} + {2'b00, q_d[3]};

      reg [31:0] nxt_data;

      always @*
      begin
        case (op)
          `OP_ABS32:
            nxt_data = (a == `S32_MIN) ? `S32_MAX : (a[31] ? neg_a : a);
          `OP_ADD32_S:
            nxt_data = (sadd[32] != sadd[31]) ? (sadd[32] ? `S32_MIN : `S32_MAX)
                                              : sadd[31:0];
          `OP_ADD32_U:
            nxt_data = uadd[32] ? `U32_MAX : uadd[31:0];
          `OP_MUL32_S:
          begin
            if (smul[63:31] == 33'h000000000 || smul[63:31] == 33'h1ffffffff)
              nxt_data = smul[31:0];
            else
              nxt_data = smul[63] ? `S32_MIN : `S32_MAX;
          end
          `OP_SUB32_S:
            nxt_data = (ssub[32] != ssub[31]) ? (ssub[32] ? `S32_MIN : `S32_MAX)
                                              : ssub[31:0];
          `OP_DUAL_ASR, `OP_DUAL_ICLIP, `OP_DUAL_UCLIP,
          `OP_DUAL_SUB, `OP_DUAL_ADD, `OP_DUAL_ABS:
            nxt_data = {h_y[1], h_y[0]};
          `OP_HALF_LO_PACK:
            nxt_data = {a[15:0], b[15:0]};
          `OP_HALF_HI_PACK:
            nxt_data = {a[31:16], b[31:16]};
          `OP_TWIN_LO_MERGE:
            nxt_data = {a[23:16], b[23:16], a[7:0], b[7:0]};
          `OP_QUAD_MAX, `OP_QUAD_MIN, `OP_QUAD_MULHI,
          `OP_QUAD_ADDUI, `OP_QUAD_AVG:
            nxt_data = {q_y[3], q_y[2], q_y[1], q_y[0]};
          `OP_HALF_DOT:   nxt_data = hdot;
          `OP_BYTE_DOT:   nxt_data = bdot;
          `OP_BYTE_SAD:   nxt_data = {22'h000000, bsad};
          default:        nxt_data = 32'h00000000;
        endcase
      end

      assign nxt_result_data[s*32 +: 32] = issue_valid[s] ? nxt_data : 32'h00000000;
    end
  endgenerate

  // one process owns both outputs so each has a single driver
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      result_valid_ff <= {SLOTS{1'b0}};
      result_data_ff  <= {SLOTS*32{1'b0}};
    end
    else
    begin
      result_valid_ff <= issue_valid;
      result_data_ff  <= nxt_result_data;
    end
  end

endmodule // packed_simd_media_alu

// File: testbench/media_alu_checker.sv
// slot 0 data assertions, an all-slot valid latency check and covers for the packed media alu
// assumes issue_valid is held low while reset is high
`timescale 1ns/1ps
`include "media_alu_map.vh"

module media_alu_checker
#(
  parameter SLOTS = 5
)
(
  // clock and reset
  input logic                    clk,
  input logic                    reset,
  // issue side
  input logic [SLOTS-1:0]        issue_valid,
  input logic [SLOTS*5-1:0]      issue_opcode,
  input logic [SLOTS*32-1:0]     issue_src1,
  input logic [SLOTS*32-1:0]     issue_src2,
  // writeback side
  input logic [SLOTS-1:0]        result_valid_ff,
  input logic [SLOTS*32-1:0]     result_data_ff
);
  wire [31:0] a0   = issue_src1[31:0];
  wire [31:0] b0   = issue_src2[31:0];
  wire [31:0] y0   = result_data_ff[31:0];
  wire [4:0]  op0  = issue_opcode[4:0];
  wire        go0  = issue_valid[0];
  wire [32:0] usum = {1'b0, a0} + {1'b0, b0};
  wire [8:0]  avg0 = ({1'b0, a0[7:0]} + b0[7:0] + 9'h001) >> 1;
  wire [7:0]  max0 = (a0[7:0] > b0[7:0]) ? a0[7:0] : b0[7:0];
  wire [15:0] mul0 = a0[31:24] * b0[31:24];
  wire [31:0] abs0 = (a0 == `S32_MIN) ? `S32_MAX : (a0[31] ? -a0 : a0);

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  chk_valid_latency: assert property (!$past(reset) |-> result_valid_ff == $past(issue_valid))
    else $error("result valid is not the issue one cycle later");
  chk_lo_pack: assert property (go0 && op0 == `OP_HALF_LO_PACK |=> y0 == $past({a0[15:0], b0[15:0]}))
    else $error("low halfword pack wrong");
  chk_hi_pack: assert property (go0 && op0 == `OP_HALF_HI_PACK ##1 1'b1 |-> y0[31:16] == $past(a0[31:16]) && y0[15:0] == $past(b0[31:16]))
    else $error("high halfword pack wrong");
  chk_lane_merge: assert property (go0 && op0 == `OP_TWIN_LO_MERGE |=> y0 == $past({a0[23:16], b0[23:16], a0[7:0], b0[7:0]}))
    else $error("twin low byte merge wrong");
  chk_byte_max: assert property (go0 && op0 == `OP_QUAD_MAX |=> y0[7:0] == $past(max0))
    else $error("byte max lane 0 wrong");
  chk_byte_avg: assert property (go0 && op0 == `OP_QUAD_AVG |=> y0[7:0] == $past(avg0[7:0]))
    else $error("byte average lane 0 wrong");
  chk_uadd_clip: assert property (go0 && op0 == `OP_ADD32_U |=> y0 == $past(usum[32] ? `U32_MAX : usum[31:0]))
    else $error("unsigned clipped add wrong");
  chk_abs_sat: assert property (go0 && op0 == `OP_ABS32 |=> y0 == $past(abs0))
    else $error("clipped absolute value wrong");
  chk_mulhi_top: assert property (go0 && op0 == `OP_QUAD_MULHI |=> y0[31:24] == $past(mul0[15:8]))
    else $error("multiply high lane 3 wrong");
  chk_idle_zero: assert property (!go0 |=> y0 == 32'h00000000)
    else $error("idle slot 0 result not zero");

  cov_all_slots: cover property (&issue_valid ##1 &result_valid_ff);
  cov_back2back: cover property (go0 ##1 go0);
  cov_abs_min: cover property (go0 && op0 == `OP_ABS32 && a0 == `S32_MIN);
endmodule // media_alu_checker

bind packed_simd_media_alu media_alu_checker #(.SLOTS(SLOTS)) chk_i
(
  .clk(clk),
  .reset(reset),
  .issue_valid(issue_valid),
  .issue_opcode(issue_opcode),
  .issue_src1(issue_src1),
  .issue_src2(issue_src2),
  .result_valid_ff(result_valid_ff),
  .result_data_ff(result_data_ff)
);

// File: testbench/regfile_model.sv
// register file side of the writeback: counts results written back
// assumes one write per set valid bit per cycle
`timescale 1ns/1ps

module regfile_model
#(
  parameter SLOTS = 5
)
(
  // clock and reset
  input  logic                clk,
  input  logic                reset,
  // writeback from the alu
  input  logic [SLOTS-1:0]    wb_valid,
  // total for the bench
  output int                  wb_count
);
  always @(posedge clk or posedge reset)
    if (reset)
      wb_count <= 0;
    else
      wb_count <= wb_count + $countones(wb_valid);
endmodule // regfile_model

// File: testbench/packed_simd_media_alu_tb.sv
// self-checking bench: table of operations on all slots, then edge cases
// assumes the one-cycle result latency of the alu
`timescale 1ns/1ps
`include "media_alu_map.vh"

module packed_simd_media_alu_tb;
  localparam SLOTS = 5;
  logic                clk;
  logic                reset;
  logic [SLOTS-1:0]    issue_valid;
  logic [SLOTS*5-1:0]  issue_opcode;
  logic [SLOTS*32-1:0] issue_src1;
  logic [SLOTS*32-1:0] issue_src2;
  wire  [SLOTS-1:0]    result_valid_ff;
  wire  [SLOTS*32-1:0] result_data_ff;
  int                  wb_count;
  int                  n_fail;
  int                  total_checks;
  int                  i;
  int                  s;
  // op, a, b, expected
  logic [100:0] rows [0:21] = '{
    {`OP_ABS32, 32'h80000000, 32'h0, 32'h7fffffff},
    {`OP_ADD32_S, 32'h7fffffff, 32'h1, 32'h7fffffff},
    {`OP_ADD32_U, 32'hffffffff, 32'h2, 32'hffffffff},
    {`OP_MUL32_S, 32'h00010000, 32'hffff0000, 32'h80000000},
    {`OP_SUB32_S, 32'h80000000, 32'h1, 32'h80000000},
    {`OP_DUAL_ASR, 32'h80004000, 32'h1, 32'hc0002000},
    {`OP_DUAL_ICLIP, 32'h80000123, 32'h01000100, 32'hff000100},
    {`OP_DUAL_UCLIP, 32'hffff0200, 32'h01000100, 32'h00000100},
    {`OP_DUAL_SUB, 32'h80007fff, 32'h0001ffff, 32'h80007fff},
    {`OP_HALF_LO_PACK, 32'h11112222, 32'h33334444, 32'h22224444},
    {`OP_HALF_HI_PACK, 32'h11112222, 32'h33334444, 32'h11113333},
    {`OP_TWIN_LO_MERGE, 32'ha1a2a3a4, 32'hb1b2b3b4, 32'ha2b2a4b4},
    {`OP_QUAD_MAX, 32'h00ff7f80, 32'h01fe8081, 32'h01ff8081},
    {`OP_QUAD_MIN, 32'h00ff7f80, 32'h01fe8081, 32'h00fe7f80},
    {`OP_QUAD_MULHI, 32'hff100200, 32'hff100380, 32'hfe010000},
    {`OP_QUAD_ADDUI, 32'hf0108005, 32'h20e07ffb, 32'hff00ff00},
    {`OP_HALF_DOT, 32'h0002fffd, 32'h00040005, 32'hfffffff9},
    {`OP_BYTE_DOT, 32'h01ff0280, 32'h0203fe01, 32'hffffff7b},
    {`OP_BYTE_SAD, 32'h807f0005, 32'h7f800105, 32'h000001ff},
    {`OP_QUAD_AVG, 32'hff0001fe, 32'hff0102fe, 32'hff0102fe},
    {`OP_DUAL_ADD, 32'h7fff8000, 32'h0001ffff, 32'h7fff8000},
    {5'h1f, 32'h12345678, 32'h9abcdef0, 32'h0}};

  packed_simd_media_alu #(.SLOTS(SLOTS)) uut
  (
    .clk(clk),
    .reset(reset),
    .issue_valid(issue_valid),
    .issue_opcode(issue_opcode),
    .issue_src1(issue_src1),
    .issue_src2(issue_src2),
    .result_valid_ff(result_valid_ff),
    .result_data_ff(result_data_ff)
  );

  regfile_model #(.SLOTS(SLOTS)) rf
  (
    .clk(clk),
    .reset(reset),
    .wb_valid(result_valid_ff),
    .wb_count(wb_count)
  );

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // drive every slot with the same operation, valid bits per mask
  task automatic issue(input logic [SLOTS-1:0] v, input logic [4:0] op,
                       input logic [31:0] a, input logic [31:0] b);
    @(posedge clk);
    issue_valid <= v;
    issue_opcode <= {SLOTS{op}};
    issue_src1 <= {SLOTS{a}};
    issue_src2 <= {SLOTS{b}};
  endtask

  task tally_and_finish;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // cut off a hung run
  initial
  begin
    #100000;
    n_fail++;
    tally_and_finish;
  end

  initial
  begin
    reset = 1'b1;
    issue_valid = '0;
    issue_opcode = '0;
    issue_src1 = '0;
    issue_src2 = '0;
    n_fail = 0;
    total_checks = 0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    for (i = 0; i < 22; i++)
    begin
      issue('1, rows[i][100:96], rows[i][95:64], rows[i][63:32]);
      @(posedge clk);
      #1;
      for (s = 0; s < SLOTS; s++)
      begin
        check("valid", {31'h0, result_valid_ff[s]}, 32'h1);
        check("data", result_data_ff[32*s +: 32], rows[i][31:0]);
      end
    end
    // back-to-back issues in different slots; idle slots read zero
    issue(5'b00001, `OP_QUAD_AVG, 32'h00ff0080, 32'h00ff0181);
    issue(5'b10000, `OP_DUAL_ABS, 32'h8000fffb, 32'h0);
    #1;
    check("b2b slot0", result_data_ff[31:0], 32'h00ff0181);
    check("b2b valid", {27'h0, result_valid_ff}, 32'h00000001);
    check("idle slot4", result_data_ff[159:128], 32'h0);
    issue('0, `OP_ABS32, 32'h0, 32'h0);
    #1;
    check("dual abs", result_data_ff[159:128], 32'h7fff0005);
    check("slot4 valid", {27'h0, result_valid_ff}, 32'h00000010);
    check("idle slot0", result_data_ff[31:0], 32'h0);
    @(posedge clk);
    #1;
    check("writebacks", wb_count, 32'd222);
    // reset in mid-run clears the outputs at once
    issue('1, `OP_ADD32_U, 32'h1, 32'h1);
    @(posedge clk);
    reset <= 1'b1;
    #1;
    check("reset valid", {27'h0, result_valid_ff}, 32'h0);
    check("reset data", result_data_ff[31:0], 32'h0);
    issue('0, `OP_ABS32, 32'h0, 32'h0);
    reset <= 1'b0;
    issue(5'b00001, `OP_ADD32_U, 32'hfffffff0, 32'h00000011);
    @(posedge clk);
    #1;
    check("after reset", result_data_ff[31:0], 32'hffffffff);
    tally_and_finish;
  end
endmodule // packed_simd_media_alu_tb
